// *** verilog/trdd_consts.vh ***
// Constants for the routing and DMA select control register block.
// Assumes inclusion by bare name from design files only.
`ifndef TRDD_CONSTS_VH
`define TRDD_CONSTS_VH

`define TRDD_ADDR_W 4
`define TRDD_OFS_CTRL 4'h2
`define TRDD_DATA_W 16
`define TRDD_HI_RESET 8'h00
`define TRDD_READ_ZERO 16'h0000
`define TRDD_BIT_L4_TRIG 15
`define TRDD_BIT_C5_L4 14
`define TRDD_BIT_L2_GATE 13
`define TRDD_BIT_C2_L2 12
`define TRDD_BIT_C1_BIP 11
`define TRDD_BIT_C0_BIP 10
`define TRDD_BIT_C1_EXT 9
`define TRDD_BIT_C0_EXT 8
`define TRDD_BIT_DEMAND 7
`define TRDD_PRI_LO 0
`define TRDD_PRI_HI 2
`define TRDD_SEC_LO 3
`define TRDD_SEC_HI 5
`define TRDD_SEL_W 3
`define TRDD_NUM_CH 8
`define TRDD_SEL_NONE 3'h4
`define TRDD_CH_NONE 8'h00

`endif

// *** verilog/trdd_chan_decode.v ***
// Decodes one channel-select field into one-hot host DMA request lines.
// Assumes the field is held stable by the register bank.
`timescale 1ns/1ps
`include "trdd_consts.vh"

module trdd_chan_decode (
    input wire [`TRDD_SEL_W-1:0] i_sel,
    input wire i_req,
    input wire [`TRDD_NUM_CH-1:0] i_dack,
    output wire [`TRDD_NUM_CH-1:0] o_dreq,
    output wire o_ack
);
    wire [`TRDD_NUM_CH-1:0] onehot;
    genvar g;
    generate
        for (g = 0; g < `TRDD_NUM_CH; g = g + 1) begin : g_ch
            // Code 100 matches no line, so nothing is requested or heard.
            assign onehot[g] = (i_sel == g) && (i_sel != `TRDD_SEL_NONE);
        end
    endgenerate
    assign o_dreq = i_req ? onehot : `TRDD_CH_NONE;
    assign o_ack = |(onehot & i_dack);
endmodule

// *** verilog/trdd_route.v ***
// Trigger bus routing: receive muxes and driver enables for lines 2 and 4.
// Assumes all control bits come from registered flip-flops.
`timescale 1ns/1ps
`include "trdd_consts.vh"

module trdd_route (
    input wire i_l4_trig_sel,
    input wire i_c5_drv,
    input wire i_l2_gate_sel,
    input wire i_c2_drv,
    input wire i_bus_line4,
    input wire i_bus_line2,
    input wire i_connector_timer_trigger_n,
    input wire i_connector_gate,
    input wire i_counter_five_output,
    input wire i_counter_two_output,
    output wire o_timer_trigger_n,
    output wire o_counter_one_gate,
    output wire o_line4_out,
    output wire o_line4_oe,
    output wire o_line2_out,
    output wire o_line2_oe
);
    assign o_timer_trigger_n = i_l4_trig_sel ? i_bus_line4 :
        i_connector_timer_trigger_n;
    assign o_counter_one_gate = i_l2_gate_sel ? i_bus_line2 :
        i_connector_gate;
    assign o_line4_out = i_counter_five_output;
    assign o_line4_oe = i_c5_drv;
    assign o_line2_out = i_counter_two_output;
    assign o_line2_oe = i_c2_drv;
endmodule

// *** verilog/trdd_top.v ***
// Routing and DMA select control register, reached over Avalon-MM.
// Assumes one 10 MHz clock, synchronous active-low reset, word addresses.
//
// Contract
// - Write-only 16-bit register at offset 02 hex; reads return zero.
// - Bits 8-15 clear at power-up and on every reset.
// - Bits 0-7 are undefined at power-up and keep their value across reset.
// - Bit 15 set takes the timer trigger from bus line 4, else connector.
// - In delayed update mode the timer trigger updates the converters.
// - Bit 14 set drives counter five onto bus line 4, else releases it.
// - Bit 13 set makes bus line 2 the counter-one gate, ignoring connector.
// - Bit 12 set drives counter two onto bus line 2, else releases it.
// - Bit 11 sets converter one bipolar two's complement, else unipolar.
// - Bit 10 sets converter zero bipolar two's complement, else unipolar.
// - Bit 9 selects external reference for converter one, else internal.
// - Bit 8 selects external reference for converter zero, else internal.
// - Bit 7 set selects demand-mode DMA, clear selects single transfer.
// - Bits 2-0 choose the primary DMA channel.
// - Bits 5-3 choose the secondary DMA channel.
// - Codes 0-3 and 5-7 map to those channels; code 100 selects none.
// - Enabled requests go out on the channel selected by its field.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "trdd_consts.vh"

module trdd_top (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire [`TRDD_ADDR_W-1:0] i_avs_address,
    input wire i_avs_write,
    input wire i_avs_read,
    input wire [`TRDD_DATA_W-1:0] i_avs_writedata,
    input wire [1:0] i_avs_byteenable,
    output reg [`TRDD_DATA_W-1:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    input wire i_bus_line4,
    input wire i_bus_line2,
    input wire i_connector_timer_trigger_n,
    input wire i_connector_gate,
    input wire i_counter_five_output,
    input wire i_counter_two_output,
    input wire i_delayed_update_mode,
    input wire i_primary_request_enable,
    input wire i_secondary_request_enable,
    input wire [`TRDD_NUM_CH-1:0] i_dma_ack,
    output reg o_timer_trigger_n,
    output reg o_counter_one_gate,
    output reg o_bus_line4_out,
    output reg o_bus_line4_oe,
    output reg o_bus_line2_out,
    output reg o_bus_line2_oe,
    output reg o_converter_update_n,
    output reg o_converter_one_bipolar,
    output reg o_converter_zero_bipolar,
    output reg o_converter_one_external_reference,
    output reg o_converter_zero_external_reference,
    output reg o_demand_transfer_select,
    output reg [`TRDD_SEL_W-1:0] o_primary_channel_select,
    output reg [`TRDD_SEL_W-1:0] o_secondary_channel_select,
    output reg [`TRDD_NUM_CH-1:0] o_dma_req,
    output reg o_primary_ack,
    output reg o_secondary_ack
);
    // Upper byte is reset; lower byte is deliberately left out of reset.
    reg [7:0] hi_r;
    reg [7:0] lo_r;
    reg [`TRDD_DATA_W-1:0] ctrl_nxt;
    wire sel_hit;
    wire wr_hit;
    wire [`TRDD_DATA_W-1:0] ctrl;
    wire trig_n;
    wire gate;
    wire l4_out;
    wire l4_oe;
    wire l2_out;
    wire l2_oe;
    wire [`TRDD_NUM_CH-1:0] pri_req;
    wire [`TRDD_NUM_CH-1:0] sec_req;
    wire pri_ack;
    wire sec_ack;
    // Named views of the stored word, so each field is decoded once.
    wire ctl_l4_trig;
    wire ctl_c5_l4;
    wire ctl_l2_gate;
    wire ctl_c2_l2;
    wire ctl_c1_bip;
    wire ctl_c0_bip;
    wire ctl_c1_ext;
    wire ctl_c0_ext;
    wire ctl_demand;
    wire [`TRDD_SEL_W-1:0] pri_sel;
    wire [`TRDD_SEL_W-1:0] sec_sel;

    assign sel_hit = (i_avs_address == `TRDD_OFS_CTRL);
    // A transfer completes on the first cycle waitrequest is seen low.
    assign wr_hit = i_avs_write && sel_hit && !o_avs_waitrequest;
    assign ctrl = {hi_r, lo_r};

    assign ctl_l4_trig = ctrl[`TRDD_BIT_L4_TRIG];
    assign ctl_c5_l4 = ctrl[`TRDD_BIT_C5_L4];
    assign ctl_l2_gate = ctrl[`TRDD_BIT_L2_GATE];
    assign ctl_c2_l2 = ctrl[`TRDD_BIT_C2_L2];
    assign ctl_c1_bip = ctrl[`TRDD_BIT_C1_BIP];
    assign ctl_c0_bip = ctrl[`TRDD_BIT_C0_BIP];
    assign ctl_c1_ext = ctrl[`TRDD_BIT_C1_EXT];
    assign ctl_c0_ext = ctrl[`TRDD_BIT_C0_EXT];
    assign ctl_demand = ctrl[`TRDD_BIT_DEMAND];
    assign pri_sel = ctrl[`TRDD_PRI_HI:`TRDD_PRI_LO];
    assign sec_sel = ctrl[`TRDD_SEC_HI:`TRDD_SEC_LO];

    always @* begin
        ctrl_nxt = ctrl;
        if (wr_hit) begin
            // Byte enables are honoured, full-word writes load all 16 bits.
            if (i_avs_byteenable[1]) begin
                ctrl_nxt[15:8] = i_avs_writedata[15:8];
            end
            if (i_avs_byteenable[0]) begin
                ctrl_nxt[7:0] = i_avs_writedata[7:0];
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            hi_r <= `TRDD_HI_RESET;
        end else begin
            hi_r <= ctrl_nxt[15:8];
        end
    end

    // No reset branch: the low byte survives reset unchanged.
    always @(posedge i_sys_clk) begin
        lo_r <= ctrl_nxt[7:0];
    end

    // One wait cycle per access keeps the answer a single registered cycle.
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= `TRDD_READ_ZERO;
        end else begin
            if ((i_avs_write || i_avs_read) && o_avs_waitrequest) begin
                o_avs_waitrequest <= 1'b0;
            end else begin
                o_avs_waitrequest <= 1'b1;
            end
            o_avs_readdata <= `TRDD_READ_ZERO;
        end
    end

    trdd_route u_route (
        .i_l4_trig_sel(ctl_l4_trig),
        .i_c5_drv(ctl_c5_l4),
        .i_l2_gate_sel(ctl_l2_gate),
        .i_c2_drv(ctl_c2_l2),
        .i_bus_line4(i_bus_line4),
        .i_bus_line2(i_bus_line2),
        .i_connector_timer_trigger_n(i_connector_timer_trigger_n),
        .i_connector_gate(i_connector_gate),
        .i_counter_five_output(i_counter_five_output),
        .i_counter_two_output(i_counter_two_output),
        .o_timer_trigger_n(trig_n),
        .o_counter_one_gate(gate),
        .o_line4_out(l4_out),
        .o_line4_oe(l4_oe),
        .o_line2_out(l2_out),
        .o_line2_oe(l2_oe)
    );

    trdd_chan_decode u_pri (
        .i_sel(lo_r[`TRDD_PRI_HI:`TRDD_PRI_LO]),
        .i_req(i_primary_request_enable),
        .i_dack(i_dma_ack),
        .o_dreq(pri_req),
        .o_ack(pri_ack)
    );

    trdd_chan_decode u_sec (
        .i_sel(lo_r[`TRDD_SEC_HI:`TRDD_SEC_LO]),
        .i_req(i_secondary_request_enable),
        .i_dack(i_dma_ack),
        .o_dreq(sec_req),
        .o_ack(sec_ack)
    );

    // Outputs are registered, so routing follows a write by one more cycle.
    // Each pin has its own flop so that its reset intent stays visible.
    always @(posedge i_sys_clk) begin
        o_timer_trigger_n <= trig_n;
    end

    always @(posedge i_sys_clk) begin
        o_counter_one_gate <= gate;
    end

    always @(posedge i_sys_clk) begin
        o_bus_line4_out <= l4_out;
    end

    always @(posedge i_sys_clk) begin
        o_bus_line2_out <= l2_out;
    end

    // The update strobe idles high outside delayed update mode.
    always @(posedge i_sys_clk) begin
        o_converter_update_n <= i_delayed_update_mode ? trig_n : 1'b1;
    end

    // Low-byte fields have no reset, so these may be unknown until written.
    always @(posedge i_sys_clk) begin
        o_primary_channel_select <= pri_sel;
    end

    always @(posedge i_sys_clk) begin
        o_secondary_channel_select <= sec_sel;
    end

    always @(posedge i_sys_clk) begin
        o_demand_transfer_select <= ctl_demand;
    end

    always @(posedge i_sys_clk) begin
        o_dma_req <= pri_req | sec_req;
    end

    always @(posedge i_sys_clk) begin
        o_primary_ack <= pri_ack;
    end

    always @(posedge i_sys_clk) begin
        o_secondary_ack <= sec_ack;
    end

    // Drivers come up released so that no other bus agent is fought.
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_bus_line4_oe <= 1'b0;
        end else begin
            o_bus_line4_oe <= l4_oe;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_bus_line2_oe <= 1'b0;
        end else begin
            o_bus_line2_oe <= l2_oe;
        end
    end

    // Converter settings fall back to unipolar with internal reference.
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_converter_one_bipolar <= 1'b0;
        end else begin
            o_converter_one_bipolar <= ctl_c1_bip;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_converter_zero_bipolar <= 1'b0;
        end else begin
            o_converter_zero_bipolar <= ctl_c0_bip;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_converter_one_external_reference <= 1'b0;
        end else begin
            o_converter_one_external_reference <= ctl_c1_ext;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_converter_zero_external_reference <= 1'b0;
        end else begin
            o_converter_zero_external_reference <= ctl_c0_ext;
        end
    end
endmodule

// *** tb/trdd_dma_model.sv ***
// Host DMA controller model that acknowledges request lines.
// Assumes registered request levels from the block under test.
`timescale 1ns/1ps
module trdd_dma_model (
    input wire i_sys_clk,
    input wire i_stall,
    input wire [7:0] i_dma_req,
    output reg [7:0] o_dma_ack
);
    initial o_dma_ack = 8'h00;
    // A stalled controller withdraws every grant, as a busy one would.
    always @(posedge i_sys_clk) begin
        o_dma_ack <= i_stall ? 8'h00 : i_dma_req;
    end
endmodule

// *** tb/trdd_chk.sv ***
// Checker for trdd_top: bus answer timing and register effects.
// Assumes one clock with a synchronous active-low reset.
`timescale 1ns/1ps
module trdd_chk (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire [3:0] i_avs_address,
    input wire i_avs_write,
    input wire i_avs_read,
    input wire [15:0] i_avs_writedata,
    input wire [1:0] i_avs_byteenable,
    input wire [15:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire o_bus_line4_oe,
    input wire o_bus_line2_oe,
    input wire o_converter_one_bipolar,
    input wire o_converter_zero_bipolar,
    input wire o_converter_one_external_reference,
    input wire o_converter_zero_external_reference,
    input wire [2:0] o_primary_channel_select,
    input wire o_primary_ack
);
    // Shadow copy; the low byte is only trusted once it has been written.
    reg [15:0] sh_r = 16'h0000;
    reg lo_r = 1'b0;
    wire tk = i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h2;
    wire [3:0] cv = {o_converter_one_bipolar, o_converter_zero_bipolar,
        o_converter_one_external_reference,
        o_converter_zero_external_reference};
    always @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            sh_r[15:8] <= 8'h00;
        end else if (tk) begin
            if (i_avs_byteenable[1]) sh_r[15:8] <= i_avs_writedata[15:8];
            if (i_avs_byteenable[0]) sh_r[7:0] <= i_avs_writedata[7:0];
            if (i_avs_byteenable[0]) lo_r <= 1'b1;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    property p_rdz; o_avs_readdata == 16'h0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not zero");
    property p_ans; (i_avs_write || i_avs_read) && o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("bus answer late");
    property p_rst; disable iff (1'b0) !i_resetn ##1 !i_resetn
        |=> !o_bus_line4_oe && !o_bus_line2_oe && cv == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("upper not cleared");
    property p_l4; o_bus_line4_oe == $past(sh_r[14]); endproperty
    a_l4: assert property (p_l4) else $error("line4 enable wrong");
    property p_l2; o_bus_line2_oe == $past(sh_r[12]); endproperty
    a_l2: assert property (p_l2) else $error("line2 enable wrong");
    property p_cnv; cv == $past(sh_r[11:8]); endproperty
    a_cnv: assert property (p_cnv) else $error("converter bits wrong");
    property p_pri; $past(lo_r)
        |-> o_primary_channel_select == $past(sh_r[2:0]); endproperty
    a_pri: assert property (p_pri) else $error("primary select wrong");
    property p_none; $past(lo_r, 2) && $past(sh_r[2:0], 2) == 3'h4
        && $past(sh_r[2:0]) == 3'h4 |-> !o_primary_ack; endproperty
    a_none: assert property (p_none) else $error("ack on no channel");
    c_wr: cover property (tk);
    c_none: cover property (lo_r && sh_r[2:0] == 3'h4);
    c_drv: cover property (o_bus_line4_oe && o_bus_line2_oe);
endmodule
bind trdd_top trdd_chk u_trdd_chk (.*);

// *** tb/tb_top.sv ***
// Testbench for trdd_top: writes, routing, channel decode and reset.
// Assumes the DMA model answers requests; trigger lines resolve here.
`timescale 1ns/1ps
module tb_top;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg stl = 1'b0;
    reg pe = 1'b0;
    reg se = 1'b0;
    reg [3:0] ad = 4'h0;
    reg [15:0] wd = 16'h0000;
    reg [1:0] be = 2'h3;
    reg [6:0] in = 7'h00;
    reg [15:0] q;
    reg [15:0] v;
    integer errors = 0;
    integer compares = 0;
    integer i;
    integer j;
    wire [15:0] rdt;
    wire wq, tr, gt, l4o, l4e, l2o, l2e, up, c1b, c0b, c1e, c0e, ds, pk, sk;
    wire [2:0] ps, ss;
    wire [7:0] rq, ak;
    // A line that the block does not drive shows the far agent's level.
    wire l4 = l4e ? l4o : in[6];
    wire l2 = l2e ? l2o : in[5];
    initial forever #50 clk = ~clk;
    trdd_top u_trdd_top (.i_sys_clk(clk), .i_resetn(rstn),
        .i_avs_address(ad), .i_avs_write(wr), .i_avs_read(rd),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdt),
        .o_avs_waitrequest(wq), .i_bus_line4(l4), .i_bus_line2(l2),
        .i_connector_timer_trigger_n(in[4]), .i_connector_gate(in[3]),
        .i_counter_five_output(in[2]), .i_counter_two_output(in[1]),
        .i_delayed_update_mode(in[0]), .i_primary_request_enable(pe),
        .i_secondary_request_enable(se), .i_dma_ack(ak),
        .o_timer_trigger_n(tr), .o_counter_one_gate(gt),
        .o_bus_line4_out(l4o), .o_bus_line4_oe(l4e), .o_bus_line2_out(l2o),
        .o_bus_line2_oe(l2e), .o_converter_update_n(up),
        .o_converter_one_bipolar(c1b), .o_converter_zero_bipolar(c0b),
        .o_converter_one_external_reference(c1e),
        .o_converter_zero_external_reference(c0e),
        .o_demand_transfer_select(ds), .o_primary_channel_select(ps),
        .o_secondary_channel_select(ss), .o_dma_req(rq),
        .o_primary_ack(pk), .o_secondary_ack(sk));
    trdd_dma_model u_trdd_dma_model (.i_sys_clk(clk), .i_stall(stl),
        .i_dma_req(rq), .o_dma_ack(ak));
    task close_out;
        begin
            $display("compares %0d errors %0d", compares, errors);
            if (errors == 0 && compares > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [63:0] n, input [15:0] s, input [15:0] e);
        begin
            compares = compares + 1;
            if (s !== e) begin
                errors = errors + 1;
                $display("ERROR %0s expected %h seen %h", n, e, s);
            end
        end
    endtask
    // The request stands until waitrequest is sampled low at a rising edge.
    task bus(input w, input [3:0] a, input [15:0] d, input [1:0] b,
        output [15:0] r);
        integer n;
        begin
            @(posedge clk);
            wr <= w;
            rd <= !w;
            ad <= a;
            wd <= d;
            be <= b;
            n = 0;
            @(posedge clk);
            while (wq !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n == 20) begin
                errors = errors + 1;
                close_out;
            end
            r = rdt;
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task st;
        begin
            repeat (4) @(posedge clk);
            @(negedge clk);
        end
    endtask
    function [7:0] m(input [2:0] x);
        m = (x == 3'h4) ? 8'h00 : 8'h01 << x;
    endfunction
    function [15:0] tab(input [1:0] k);
        tab = k == 0 ? 16'hAA2C : k == 1 ? 16'h5593 :
            k == 2 ? 16'hF03F : 16'h0F80;
    endfunction
    task ex(input [15:0] e);
        begin
            chk("oe4", l4e, e[14]);
            chk("out4", l4o, in[2]);
            chk("trig", tr, e[15] ? l4 : in[4]);
            chk("oe2", l2e, e[12]);
            chk("gate", gt, e[13] ? l2 : in[3]);
            chk("conv", {c1b, c0b, c1e, c0e}, e[11:8]);
            chk("low", {ds, ss, ps}, {e[7], e[5:0]});
            chk("upd", up, in[0] ? (e[15] ? l4 : in[4]) : 1'b1);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, 4'h2, 16'h0000, 2'h3, q);
        chk("read", q, 16'h0000);
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk);
            in <= i * 37;
            bus(1'b1, 4'h2, tab(i), 2'h3, q);
            st;
            ex(tab(i));
        end
        bus(1'b1, 4'h2, 16'hFFA1, 2'h1, q);
        st;
        ex(16'h0FA1);
        bus(1'b1, 4'h3, 16'hF03F, 2'h3, q);
        st;
        ex(16'h0FA1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        st;
        ex(16'h00A1);
        for (j = 0; j < 2; j = j + 1) begin
            for (i = 0; i < 8; i = i + 1) begin
                @(posedge clk);
                pe <= 1'b1;
                se <= j;
                bus(1'b1, 4'h2, {10'h000, ~i[2:0], i[2:0]}, 2'h3, q);
                st;
                v = m(i[2:0]) | (j ? m(~i[2:0]) : 8'h00);
                chk("req", rq, v);
                chk("pack", pk, i != 4);
                if (j) chk("sack", sk, i != 3);
            end
        end
        @(posedge clk);
        stl <= 1'b1;
        st;
        chk("stall", pk, 1'b0);
        close_out;
    end
endmodule
